// File: hw/togp_output_gate.sv
// Function
// R1: Enable bit 0 releases pin to GPIO
// R2: B outputs follow I/O control, combined mode
// R3: A outputs follow I/O, PWM, combined
// R4: Aux outputs follow combined mode only
// R5: Capture A clears enables when trigger allowed
// R6: Trigger in combined modes clears all six
// R7: Disable bit set ignores capture A
// R8: Trigger and level bits only in combined
// R9: Control register 8 bits, read/write
// R10: Control register all ones on reset, standby
// R11: Control reserved bits read as one
// R12: High level bit 0 inverts group
// R13: Low level bit 0 inverts group
// R14: Enable register all ones on reset, standby
// R15: Enable bits 7, 6 read one
// R16: Hardware clear beats software write
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module togp_output_gate (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB register port
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Power state
  input  wire logic        standby,
  // Timer unit settings
  input  wire logic [1:0]  combined_mode,
  input  wire logic        pwm_ch3,
  input  wire logic        pwm_ch4,
  input  wire logic        ch3_io_a_out,
  input  wire logic        ch3_io_b_out,
  input  wire logic        ch4_io_a_out,
  input  wire logic        ch4_io_b_out,
  input  wire logic        ch1_capture_a,
  // Timer waveforms before gating
  input  wire logic        ch3_a_wave,
  input  wire logic        ch3_b_wave,
  input  wire logic        ch4_a_wave,
  input  wire logic        ch4_b_wave,
  input  wire logic        ch4_aux_a_wave,
  input  wire logic        ch4_aux_b_wave,
  // Pin drive, channel 3
  output logic             ch3_a_pin_o,
  output logic             ch3_a_pin_oe,
  output logic             ch3_b_pin_o,
  output logic             ch3_b_pin_oe,
  // Pin drive, channel 4
  output logic             ch4_a_pin_o,
  output logic             ch4_a_pin_oe,
  output logic             ch4_b_pin_o,
  output logic             ch4_b_pin_oe,
  // Pin drive, channel 4 auxiliary
  output logic             ch4_aux_a_pin_o,
  output logic             ch4_aux_a_pin_oe,
  output logic             ch4_aux_b_pin_o,
  output logic             ch4_aux_b_pin_oe
);

  // ==========================================================
  // Declarations
  logic [5:0]             en_q;          // Master enable bits 5..0
  logic [5:0]             en_d;          // Next master enable
  logic                   trig_dis_q;    // ext_trigger_disable
  logic                   lvl_high_q;    // level_select_group_high
  logic                   lvl_low_q;     // level_select_group_low
  logic [7:0]             enable_rd;     // Enable register as read
  logic [7:0]             control_rd;    // Control register as read
  logic                   wr_enable;     // Write strobe, enable register
  logic                   wr_control;    // Write strobe, control register
  logic [7:0]             wr_byte;       // Write data low byte
  togp_pkg::togp_mode_t   mode;          // Decoded combined mode
  logic                   combined;      // Complementary or reset-sync
  logic                   trigger;       // Qualified external trigger
  logic [5:0]             request;       // Timer wants to drive pin
  logic [5:0]             wave;          // Raw waveforms by pin index
  logic [5:0]             invert;        // Per-pin inversion
  logic [5:0]             pin_o_w;       // Gated pin levels
  logic [5:0]             pin_oe_w;      // Gated pin enables

  // ==========================================================
  // Register bus slave
  togp_apb_slave u_apb (
    .pclk       (pclk),
    .presetn    (presetn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .enable_rd  (enable_rd),
    .control_rd (control_rd),
    .wr_enable  (wr_enable),
    .wr_control (wr_control),
    .wr_byte    (wr_byte)
  );

  // ==========================================================
  // Mode decode
  // Both low codes mean the channels run on their own
  always_comb begin
    unique case (combined_mode)
      2'h0:                mode = togp_pkg::MODE_NORMAL;
      2'h1:                mode = togp_pkg::MODE_NORMAL;
      togp_pkg::CMB_COMPL: mode = togp_pkg::MODE_COMPL;
      togp_pkg::CMB_RSYNC: mode = togp_pkg::MODE_RSYNC;
    endcase
  end

  assign combined = (mode != togp_pkg::MODE_NORMAL);

  // ==========================================================
  // External trigger qualification
  // R5: capture A with disable bit low
  // R7: disable bit high masks capture
  // R8: trigger only counts in combined modes
  assign trigger = ch1_capture_a & ~trig_dis_q & combined;

  // ==========================================================
  // Master enable next value
  // Standby first, then the trigger clear, then software
  always_comb begin
    en_d = en_q;
    if (standby) begin
      // R14: standby reloads all ones
      en_d = togp_pkg::ENABLE_RESET[5:0];
    end else if (trigger) begin
      // R6: all six cleared together
      // R16: clear wins over a write
      en_d = 6'h00;
    end else if (wr_enable) begin
      en_d = wr_byte[5:0];
    end
  end

  // Master enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // R14: reset value all ones
      en_q <= togp_pkg::ENABLE_RESET[5:0];
    end else begin
      en_q <= en_d;
    end
  end

  // ==========================================================
  // Output control register
  // Only three bits are stored; the rest are constants
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // R10: reset value all ones
      trig_dis_q <= togp_pkg::CONTROL_RESET[togp_pkg::CTRL_TDIS_BIT];
      lvl_high_q <= togp_pkg::CONTROL_RESET[togp_pkg::CTRL_HIGH_BIT];
      lvl_low_q  <= togp_pkg::CONTROL_RESET[togp_pkg::CTRL_LOW_BIT];
    end else if (standby) begin
      // R10: standby reloads all ones
      trig_dis_q <= togp_pkg::CONTROL_RESET[togp_pkg::CTRL_TDIS_BIT];
      lvl_high_q <= togp_pkg::CONTROL_RESET[togp_pkg::CTRL_HIGH_BIT];
      lvl_low_q  <= togp_pkg::CONTROL_RESET[togp_pkg::CTRL_LOW_BIT];
    end else if (wr_control) begin
      // R9: software writes the writable bits
      trig_dis_q <= wr_byte[togp_pkg::CTRL_TDIS_BIT];
      lvl_high_q <= wr_byte[togp_pkg::CTRL_HIGH_BIT];
      lvl_low_q  <= wr_byte[togp_pkg::CTRL_LOW_BIT];
    end
  end

  // ==========================================================
  // Read views
  // R15: enable bits 7 and 6 read one
  assign enable_rd = togp_pkg::ENABLE_RSVD | {2'h0, en_q};

  // R11: reserved control bits read one
  assign control_rd = togp_pkg::CONTROL_RSVD
                    | {3'h0, trig_dis_q, 2'h0, lvl_high_q, lvl_low_q};

  // ==========================================================
  // Pin ownership requests
  always_comb begin
    // R3: A outputs add single-channel PWM
    request[togp_pkg::PIN_CH3_A] = combined | pwm_ch3 | ch3_io_a_out;
    request[togp_pkg::PIN_CH4_A] = combined | pwm_ch4 | ch4_io_a_out;
    // R2: B outputs use I/O control and combined mode, no PWM
    request[togp_pkg::PIN_CH4_B] = combined | ch4_io_b_out;
    request[togp_pkg::PIN_CH3_B] = combined | ch3_io_b_out;
    // R4: auxiliary pins exist only in combined modes
    request[togp_pkg::PIN_AUX_A] = combined;
    request[togp_pkg::PIN_AUX_B] = combined;
  end

  // Raw waveforms gathered by pin index
  always_comb begin
    wave[togp_pkg::PIN_CH3_A] = ch3_a_wave;
    wave[togp_pkg::PIN_CH4_A] = ch4_a_wave;
    wave[togp_pkg::PIN_CH4_B] = ch4_b_wave;
    wave[togp_pkg::PIN_CH3_B] = ch3_b_wave;
    wave[togp_pkg::PIN_AUX_A] = ch4_aux_a_wave;
    wave[togp_pkg::PIN_AUX_B] = ch4_aux_b_wave;
  end

  // ==========================================================
  // Level select
  // R8: inversion is ignored outside combined modes
  // R12: high group inverted when bit is zero
  // R13: low group inverted when bit is zero
  assign invert = ({6{combined & ~lvl_high_q}} & togp_pkg::GROUP_HIGH_MASK)
                | ({6{combined & ~lvl_low_q}}  & togp_pkg::GROUP_LOW_MASK);

  // ==========================================================
  // Pin gate
  // R1: disabled pins drop their enable
  togp_pin_gate u_gate (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (en_q),
    .request (request),
    .wave    (wave),
    .invert  (invert),
    .pin_o   (pin_o_w),
    .pin_oe  (pin_oe_w)
  );

  // Pins fanned out to named ports
  assign ch3_a_pin_o      = pin_o_w[togp_pkg::PIN_CH3_A];
  assign ch3_a_pin_oe     = pin_oe_w[togp_pkg::PIN_CH3_A];
  assign ch3_b_pin_o      = pin_o_w[togp_pkg::PIN_CH3_B];
  assign ch3_b_pin_oe     = pin_oe_w[togp_pkg::PIN_CH3_B];
  assign ch4_a_pin_o      = pin_o_w[togp_pkg::PIN_CH4_A];
  assign ch4_a_pin_oe     = pin_oe_w[togp_pkg::PIN_CH4_A];
  assign ch4_b_pin_o      = pin_o_w[togp_pkg::PIN_CH4_B];
  assign ch4_b_pin_oe     = pin_oe_w[togp_pkg::PIN_CH4_B];
  assign ch4_aux_a_pin_o  = pin_o_w[togp_pkg::PIN_AUX_A];
  assign ch4_aux_a_pin_oe = pin_oe_w[togp_pkg::PIN_AUX_A];
  assign ch4_aux_b_pin_o  = pin_o_w[togp_pkg::PIN_AUX_B];
  assign ch4_aux_b_pin_oe = pin_oe_w[togp_pkg::PIN_AUX_B];

  // ==========================================================
  // Assertions
  // Qualified trigger with no standby in the way
  sequence s_trigger;
    trigger && !standby;
  endsequence

  // Enables gone, then every pin released
  sequence s_outputs_stop;
    (en_q == 6'h00) ##1 (pin_oe_w == 6'h00);
  endsequence

  // Setup phase of a read of the control register
  sequence s_ctrl_read_setup;
    psel && !penable && !pwrite && (paddr == togp_pkg::CONTROL_OFFSET);
  endsequence

  // A cleared enable never leaves its pin driven
  property p_gate_off;
    @(posedge pclk) disable iff (!presetn)
      1'h1 |=> ((pin_oe_w & ~$past(en_q)) == 6'h00);
  endproperty
  a_gate_off: assert property (p_gate_off) // R1
    else $error("pin driven while its enable bit is clear");

  // Enabled B pin with output I/O setting is driven
  property p_b_follows_io;
    @(posedge pclk) disable iff (!presetn)
      en_q[togp_pkg::PIN_CH3_B] && ch3_io_b_out |=> ch3_b_pin_oe;
  endproperty
  a_b_follows_io: assert property (p_b_follows_io) // R2
    else $error("channel 3 B not driven despite enable and output setting");

  // Enabled A pin in single-channel PWM is driven
  property p_a_follows_pwm;
    @(posedge pclk) disable iff (!presetn)
      en_q[togp_pkg::PIN_CH4_A] && pwm_ch4 |=> ch4_a_pin_oe;
  endproperty
  a_a_follows_pwm: assert property (p_a_follows_pwm) // R3
    else $error("channel 4 A not driven in PWM mode with enable set");

  // Auxiliary pins depend on enable and combined mode only
  property p_aux_combined_only;
    @(posedge pclk) disable iff (!presetn)
      1'h1 |=> (pin_oe_w[5:4] == ($past(en_q[5:4]) & {2{$past(combined)}}));
  endproperty
  a_aux_combined_only: assert property (p_aux_combined_only) // R4
    else $error("auxiliary pin enable does not match mode and enable");

  // Trigger clears enables, then all pins stop
  property p_trigger_stops;
    @(posedge pclk) disable iff (!presetn)
      s_trigger |=> s_outputs_stop;
  endproperty
  a_trigger_stops: assert property (p_trigger_stops) // R6
    else $error("external trigger did not stop all six outputs");

  // Disable bit set keeps the enables untouched by capture
  property p_trig_dis_masks;
    @(posedge pclk) disable iff (!presetn)
      trig_dis_q && ch1_capture_a && !standby && !wr_enable |=> $stable(en_q);
  endproperty
  a_trig_dis_masks: assert property (p_trig_dis_masks) // R7
    else $error("capture A changed enables while trigger disabled");

  // Outside combined modes pins carry the raw waveform
  property p_no_invert_normal;
    @(posedge pclk) disable iff (!presetn)
      !combined
        |=> (((pin_o_w ^ $past(wave)) & pin_oe_w) == 6'h00);
  endproperty
  a_no_invert_normal: assert property (p_no_invert_normal) // R8
    else $error("output inverted outside combined modes");

  // Standby reloads both registers to all ones
  property p_standby_reload;
    @(posedge pclk) disable iff (!presetn)
      standby |=> (enable_rd == togp_pkg::ENABLE_RESET)
                  && (control_rd == togp_pkg::CONTROL_RESET);
  endproperty
  a_standby_reload: assert property (p_standby_reload) // R10
    else $error("standby did not reload registers to all ones");

  // Control reads always show reserved ones
  property p_ctrl_reserved;
    @(posedge pclk) disable iff (!presetn)
      s_ctrl_read_setup |=>
        ((prdata[7:0] & togp_pkg::CONTROL_RSVD) == togp_pkg::CONTROL_RSVD);
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) // R11
    else $error("control reserved bits did not read as one");

  // High group inverted in combined mode when bit is zero
  property p_high_invert;
    @(posedge pclk) disable iff (!presetn)
      combined && !lvl_high_q && (en_q[2:0] == 3'h7)
        |=> (pin_o_w[2:0] == ~$past(wave[2:0]));
  endproperty
  a_high_invert: assert property (p_high_invert) // R12
    else $error("high group not inverted");

  // Low group inverted in combined mode when bit is zero
  property p_low_invert;
    @(posedge pclk) disable iff (!presetn)
      combined && !lvl_low_q && (en_q[5:3] == 3'h7)
        |=> (pin_o_w[5:3] == ~$past(wave[5:3]));
  endproperty
  a_low_invert: assert property (p_low_invert) // R13
    else $error("low group not inverted");

  // A write in the trigger cycle is lost
  property p_clear_wins;
    @(posedge pclk) disable iff (!presetn)
      s_trigger ##0 wr_enable |=> (en_q == 6'h00);
  endproperty
  a_clear_wins: assert property (p_clear_wins) // R16
    else $error("software write beat the trigger clear");

endmodule
`default_nettype wire

// File: hw/togp_pkg.sv
`default_nettype none
package togp_pkg;

  // ==========================================================
  // Bus geometry
  localparam int          ADDR_W           = 12;       // APB address width
  localparam int          DATA_W           = 32;       // APB data width
  localparam int          NUM_PINS         = 6;        // Gated timer outputs

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] ENABLE_OFFSET    = 12'h000;  // output_master_enable
  localparam logic [11:0] CONTROL_OFFSET   = 12'h004;  // output_control

  // ==========================================================
  // Reset values and reserved masks
  localparam logic [7:0]  ENABLE_RESET     = 8'hff;    // Reset and standby value
  localparam logic [7:0]  CONTROL_RESET    = 8'hff;    // Reset and standby value
  localparam logic [7:0]  ENABLE_RSVD      = 8'hc0;    // Bits 7 and 6 read as 1
  localparam logic [7:0]  CONTROL_RSVD     = 8'hec;    // Bits 7 to 5, 3, 2 read as 1

  // ==========================================================
  // Pin index, equal to the enable bit position
  localparam int          PIN_CH3_A        = 0;        // a_ch3_output_enable
  localparam int          PIN_CH4_A        = 1;        // a_ch4_output_enable
  localparam int          PIN_CH4_B        = 2;        // b_ch4_output_enable
  localparam int          PIN_CH3_B        = 3;        // b_ch3_output_enable
  localparam int          PIN_AUX_A        = 4;        // aux_a_ch4_output_enable
  localparam int          PIN_AUX_B        = 5;        // aux_b_ch4_output_enable

  // ==========================================================
  // Control register fields
  localparam int          CTRL_TDIS_BIT    = 4;        // ext_trigger_disable
  localparam int          CTRL_HIGH_BIT    = 1;        // level_select_group_high
  localparam int          CTRL_LOW_BIT     = 0;        // level_select_group_low

  // ==========================================================
  // Pin groups for level select
  localparam logic [5:0]  GROUP_HIGH_MASK  = 6'h07;    // ch3 A, ch4 A, ch4 B
  localparam logic [5:0]  GROUP_LOW_MASK   = 6'h38;    // ch3 B, aux A, aux B

  // ==========================================================
  // Combined-mode select codes
  localparam logic [1:0]  CMB_COMPL        = 2'h2;     // Complementary PWM
  localparam logic [1:0]  CMB_RSYNC        = 2'h3;     // Reset-synchronized PWM

  // Register selected by an address
  typedef enum logic [1:0] {SEL_NONE, SEL_ENABLE, SEL_CONTROL} togp_sel_t;

  // Operating mode of channels 3 and 4
  typedef enum logic [1:0] {MODE_NORMAL, MODE_COMPL, MODE_RSYNC} togp_mode_t;

  // Address decode, shared by read and write paths
  function automatic togp_sel_t togp_reg_sel(input logic [11:0] addr);
    togp_sel_t sel;
    sel = SEL_NONE;
    if (addr == ENABLE_OFFSET) begin
      sel = SEL_ENABLE;
    end else if (addr == CONTROL_OFFSET) begin
      sel = SEL_CONTROL;
    end
    return sel;
  endfunction

endpackage
`default_nettype wire

// File: hw/togp_apb_slave.sv
`timescale 1ns/100ps
`default_nettype none
module togp_apb_slave (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave side
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Register side
  input  wire logic [7:0]  enable_rd,
  input  wire logic [7:0]  control_rd,
  output logic             wr_enable,
  output logic             wr_control,
  output logic      [7:0]  wr_byte
);

  // ==========================================================
  // Decode
  togp_pkg::togp_sel_t sel;         // Register addressed now
  logic                access;      // Access phase of a transfer
  logic [31:0]         prdata_q;    // Read data, caught in setup
  logic                pslverr_q;   // Unmapped flag, caught in setup

  assign sel    = togp_pkg::togp_reg_sel(paddr);
  assign access = psel & penable;

  // Zero wait states: every access phase completes at once
  assign pready     = access;
  assign wr_enable  = access & pwrite & (sel == togp_pkg::SEL_ENABLE);
  assign wr_control = access & pwrite & (sel == togp_pkg::SEL_CONTROL);
  assign wr_byte    = pwdata[7:0];
  assign prdata     = prdata_q;
  assign pslverr    = pslverr_q;

  // ==========================================================
  // Read data and error caught at the setup edge
  // Flopped so that read data never glitches during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'h0;
    end else if (psel && !penable) begin
      unique case (sel)
        togp_pkg::SEL_ENABLE:  prdata_q <= {24'h00_0000, enable_rd};
        togp_pkg::SEL_CONTROL: prdata_q <= {24'h00_0000, control_rd};
        togp_pkg::SEL_NONE:    prdata_q <= 32'h0000_0000;
      endcase
      pslverr_q <= (sel == togp_pkg::SEL_NONE);
    end
  end

endmodule
`default_nettype wire

// File: hw/togp_pin_gate.sv
`timescale 1ns/100ps
`default_nettype none
module togp_pin_gate (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Per-pin controls
  input  wire logic [5:0] enable,
  input  wire logic [5:0] request,
  input  wire logic [5:0] wave,
  input  wire logic [5:0] invert,
  // Pin drive
  output logic      [5:0] pin_o,
  output logic      [5:0] pin_oe
);

  // ==========================================================
  // One flop pair per pin; disabled pins go low and undriven
  genvar i;
  generate
    for (i = 0; i < togp_pkg::NUM_PINS; i++) begin : g_pin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_oe[i] <= 1'h0;
          pin_o[i]  <= 1'h0;
        end else begin
          pin_oe[i] <= enable[i] & request[i];
          pin_o[i]  <= enable[i] & request[i] & (wave[i] ^ invert[i]);
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// File: verification/togp_power_stage.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Power stage at the far side of the six timer pins
module togp_power_stage (
  // Pin drive from the gate
  input  wire logic [5:0] pin_o,
  input  wire logic [5:0] pin_oe,
  // Level seen by the gate drivers
  output logic      [5:0] pin_lvl
);
  // Gate drivers carry pull-downs, so a released pin reads low,
  // never a stale driven value
  always_comb begin
    pin_lvl = pin_o & pin_oe;
  end
endmodule
`default_nettype wire

// File: verification/tb_timer_output_gate_and_polarity.sv
`timescale 1ns/100ps
`default_nettype none
module tb_timer_output_gate_and_polarity;
  // ==========================================================
  // Stimulus and observed signals
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        standby = 1'h0;
  logic [1:0]  cmode = 2'h0;        // Normal mode first
  logic        pwm3 = 1'h1;
  logic        pwm4 = 1'h0;
  logic [3:0]  io_v = 4'ha;         // ch4_b, ch4_a, ch3_b, ch3_a
  logic        cap = 1'h0;
  logic [5:0]  wave_v = 6'h2d;      // Indexed like the enable bits
  wire  [5:0]  o_v;                 // Nets: each bit has its own port
  wire  [5:0]  oe_v;
  wire  [5:0]  lvl_v;
  logic [31:0] rdat;
  logic        rerr;
  int          num_errors = 0;
  int          n_checks = 0;

  always #5 pclk = ~pclk;

  // ==========================================================
  // Design and far side
  togp_output_gate DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .standby(standby),
    .combined_mode(cmode), .pwm_ch3(pwm3), .pwm_ch4(pwm4),
    .ch3_io_a_out(io_v[0]), .ch3_io_b_out(io_v[1]),
    .ch4_io_a_out(io_v[2]), .ch4_io_b_out(io_v[3]), .ch1_capture_a(cap),
    .ch3_a_wave(wave_v[0]), .ch4_a_wave(wave_v[1]), .ch4_b_wave(wave_v[2]),
    .ch3_b_wave(wave_v[3]), .ch4_aux_a_wave(wave_v[4]),
    .ch4_aux_b_wave(wave_v[5]),
    .ch3_a_pin_o(o_v[0]), .ch3_a_pin_oe(oe_v[0]),
    .ch4_a_pin_o(o_v[1]), .ch4_a_pin_oe(oe_v[1]),
    .ch4_b_pin_o(o_v[2]), .ch4_b_pin_oe(oe_v[2]),
    .ch3_b_pin_o(o_v[3]), .ch3_b_pin_oe(oe_v[3]),
    .ch4_aux_a_pin_o(o_v[4]), .ch4_aux_a_pin_oe(oe_v[4]),
    .ch4_aux_b_pin_o(o_v[5]), .ch4_aux_b_pin_oe(oe_v[5]));
  togp_power_stage stage (.pin_o(o_v), .pin_oe(oe_v), .pin_lvl(lvl_v));

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // APB transfer; trig pulses capture in the access cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic trig);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    cap <= trig;
    // Wait for pready at a rising edge; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    cap <= 1'h0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'h0, a, 8'h00, 1'h0);
    chk(rdat, exp);
    chk({31'h0, rerr}, {31'h0, eerr});
  endtask

  // Pins settle one edge after a register or input change
  task automatic pins(input logic [5:0] eoe, input logic [5:0] elvl);
    repeat (3) @(posedge pclk);
    #1;
    chk({26'h0, oe_v}, {26'h0, eoe});
    chk({26'h0, lvl_v}, {26'h0, elvl});
    // Undriven pins must also drive low
    chk({26'h0, o_v}, {26'h0, elvl});
  endtask

  task automatic pulse;
    @(posedge pclk);
    cap <= 1'h1;
    @(posedge pclk);
    cap <= 1'h0;
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rd(12'h000, 32'hff, 1'h0);                 // reset value
    rd(12'h004, 32'hff, 1'h0);                 // reset value
    rd(12'h008, 32'h0, 1'h1);                  // Unmapped read refused
    apb(1'h1, 12'h000, 8'h00, 1'h0);           // clear all enables
    rd(12'h000, 32'hc0, 1'h0);                 // reserved read one
    pins(6'h00, 6'h00);                        // pins released
    apb(1'h1, 12'h000, 8'h3f, 1'h0);           // enable all pins
    apb(1'h1, 12'h004, 8'h00, 1'h0);           // write control
    rd(12'h004, 32'hec, 1'h0);                 // reserved bits
    // Second normal-mode code
    cmode <= 2'h1;
    pins(6'h0d, 6'h0d);                        // normal mode
    pulse();                                   // capture in normal mode
    rd(12'h000, 32'hff, 1'h0);                 // trigger off in normal
    pwm4 <= 1'h1;
    pins(6'h0f, 6'h0d);                        // PWM drives ch4 A
    cmode <= 2'h2;
    pins(6'h3f, 6'h12);                        // both inverted
    apb(1'h1, 12'h004, 8'h01, 1'h0);           // high group only
    pins(6'h3f, 6'h2a);                        // high group inverted
    apb(1'h1, 12'h004, 8'h12, 1'h0);           // disable, low group
    pins(6'h3f, 6'h15);                        // low group inverted
    pulse();                                   // capture while disabled
    rd(12'h000, 32'hff, 1'h0);                 // trigger ignored
    apb(1'h1, 12'h004, 8'h02, 1'h0);           // allow trigger
    cmode <= 2'h3;
    pulse();                                   // trigger in reset-sync
    rd(12'h000, 32'hc0, 1'h0);                 // trigger clears
    pins(6'h00, 6'h00);                        // all outputs stop
    apb(1'h1, 12'h000, 8'h3f, 1'h1);           // write with trigger
    rd(12'h000, 32'hc0, 1'h0);                 // clear beats write
    @(posedge pclk);
    standby <= 1'h1;
    @(posedge pclk);
    standby <= 1'h0;
    rd(12'h000, 32'hff, 1'h0);                 // standby reload
    rd(12'h004, 32'hff, 1'h0);                 // standby reload
    stop_test();
  end

  // Watchdog, far beyond the roughly 90 cycles needed
  initial begin
    #20000;
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
